//--- design/slk_ir_decode.v
`timescale 1ns/1ns
`include "slk_consts.vh"

module slk_ir_decode (
   input wire CORE_CLK_I,                    // core clock, 25 MHz
   input wire RST_I,                         // synchronous reset, active high
   input wire TCK_I,                         // test clock pin
   input wire TMS_I,                         // test mode select pin
   input wire TDI_I,                         // serial data input pin
   input wire TRST_N_I,                      // test reset pin, active low
   input wire SECONDARY_DATA_RETURN_I,       // serial return from secondary paths
   input wire CONDITION_IN_I,                // condition input pin
   input wire [`SLK_IDB_W-1:0] IDBUS_I,      // identification bus pins
   output wire TDO_O,                        // serial data output
   output wire TDO_OE_O,                     // serial data output enable
   output wire CONDITION_OUT_O,              // condition output level
   output wire CONDITION_OUT_OE_O,           // condition output enable
   output wire [`SLK_SEL_W-1:0] PATH_SELECT_O, // secondary path select latch
   output wire TEST_MODE_O,                  // boundary test mode active
   output wire PINS_DISABLE_O,               // secondary pins disabled
   output wire [`SLK_CNT_W-1:0] COUNT_O      // counter value
);

   localparam [15:0] ST_TLR = 16'h0001;
   localparam [15:0] ST_RTI = 16'h0002;
   localparam [15:0] ST_SEL_DR = 16'h0004;
   localparam [15:0] ST_CAP_DR = 16'h0008;
   localparam [15:0] ST_SH_DR = 16'h0010;
   localparam [15:0] ST_EX1_DR = 16'h0020;
   localparam [15:0] ST_PA_DR = 16'h0040;
   localparam [15:0] ST_EX2_DR = 16'h0080;
   localparam [15:0] ST_UP_DR = 16'h0100;
   localparam [15:0] ST_SEL_IR = 16'h0200;
   localparam [15:0] ST_CAP_IR = 16'h0400;
   localparam [15:0] ST_SH_IR = 16'h0800;
   localparam [15:0] ST_EX1_IR = 16'h1000;
   localparam [15:0] ST_PA_IR = 16'h2000;
   localparam [15:0] ST_EX2_IR = 16'h4000;
   localparam [15:0] ST_UP_IR = 16'h8000;

   wire [`SLK_SYNC_W-1:0] pins;
   wire tck;
   wire tms;
   wire tdi;
   wire trst_n;
   wire ret_in;
   wire cond_pin;
   wire [`SLK_IDB_W-1:0] idbus;

   wire [`SLK_SYNC_W-1:0] pins_raw;
   // All pins share one delay, so test clock and data stay in step
   assign pins_raw = {IDBUS_I, CONDITION_IN_I, SECONDARY_DATA_RETURN_I,
      TRST_N_I, TDI_I, TMS_I, TCK_I};

   slk_sync u_sync (
      .clk_i(CORE_CLK_I),
      .rst_i(RST_I),
      .async_i(pins_raw),
      .stable_o(pins)
   );

   assign tck = pins[`SLK_SY_TCK];
   assign tms = pins[`SLK_SY_TMS];
   assign tdi = pins[`SLK_SY_TDI];
   assign trst_n = pins[`SLK_SY_TRST];
   assign ret_in = pins[`SLK_SY_RET];
   assign cond_pin = pins[`SLK_SY_COND];
   assign idbus = pins[`SLK_SY_IDB +: `SLK_IDB_W];

   reg tck_prev_reg;
   wire tck_rise;
   wire tck_fall;
   assign tck_rise = tck & ~tck_prev_reg;
   assign tck_fall = ~tck & tck_prev_reg;

   reg [15:0] state_reg;
   reg [15:0] state_next;
   reg [`SLK_IR_W-1:0] ir_shift_reg;
   reg [`SLK_IR_W-1:0] ir_latch_reg;
   reg perr_n_latch_reg;
   reg bypass_reg;
   reg [`SLK_BSR_W-1:0] bsr_reg;
   reg [`SLK_BSR_W-1:0] bsr_latch_reg;
   reg [`SLK_CTRL_W-1:0] ctrl_shift_reg;
   reg [`SLK_CTRL_W-1:0] ctrl_reg;
   reg [`SLK_CNT_W-1:0] cnt_shift_reg;
   reg [`SLK_CNT_W-1:0] count_reg;
   reg [`SLK_CNT_W-1:0] preload_reg;
   reg [`SLK_SEL_W-1:0] sel_shift_reg;
   reg [`SLK_SEL_W-1:0] sel_reg;
   reg tdo_reg;
   reg tdo_oe_reg;
   reg cond_prev_reg;
   reg cond_out_reg;
   reg cond_oe_reg;
   // Mode flop loaded with the latch, so the pin never glitches on decode
   reg test_mode_reg;

   // Decoded from the shadow latch only, never from the shifting stage
   function [2:0] dr_select;
      input [`SLK_IR_W-1:0] op;
      begin
         case (op)
            `SLK_OP_EXTEST, `SLK_OP_INTEST, `SLK_OP_SAMPLE: dr_select = `SLK_DR_BSR;
            `SLK_OP_CTRL_A, `SLK_OP_CTRL_B: dr_select = `SLK_DR_CTRL;
            `SLK_OP_CNT_SCAN, `SLK_OP_CNT_READ: dr_select = `SLK_DR_CNT;
            `SLK_OP_IDB_SCAN, `SLK_OP_IDB_READ: dr_select = `SLK_DR_IDB;
            `SLK_OP_SEL_SCAN: dr_select = `SLK_DR_SEL;
            default: dr_select = `SLK_DR_BYPASS;
         endcase
      end
   endfunction

   function is_test_op;
      input [`SLK_IR_W-1:0] op;
      begin
         is_test_op = (op == `SLK_OP_EXTEST) || (op == `SLK_OP_INTEST);
      end
   endfunction

   function is_count_op;
      input [`SLK_IR_W-1:0] op;
      begin
         is_count_op = (op == `SLK_OP_COUNT_A) || (op == `SLK_OP_COUNT_B);
      end
   endfunction

   wire [2:0] dr_sel;
   wire test_mode;
   wire count_op;
   wire perr_n;
   wire cond_active;
   wire dr_in;
   reg dr_lsb;

   assign dr_sel = dr_select(ir_latch_reg);
   assign test_mode = test_mode_reg;
   assign count_op = is_count_op(ir_latch_reg);
   assign perr_n = ~^ir_shift_reg;
   assign cond_active = cond_pin ~^ ctrl_reg[`SLK_CT_IN_POL];
   // Bypass chain picks up the secondary return when any path is linked
   assign dr_in = ((dr_sel == `SLK_DR_BYPASS) && (sel_reg != {`SLK_SEL_W{1'b0}})) ? ret_in : tdi;

   // Applied only on a detected test-clock rise
   always @* begin
      case (state_reg)
         ST_TLR: state_next = tms ? ST_TLR : ST_RTI;
         ST_RTI: state_next = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: state_next = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: state_next = tms ? ST_UP_DR : ST_PA_DR;
         ST_PA_DR: state_next = tms ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: state_next = tms ? ST_UP_DR : ST_SH_DR;
         ST_UP_DR: state_next = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: state_next = tms ? ST_TLR : ST_CAP_IR;
         ST_CAP_IR: state_next = tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: state_next = tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: state_next = tms ? ST_UP_IR : ST_PA_IR;
         ST_PA_IR: state_next = tms ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: state_next = tms ? ST_UP_IR : ST_SH_IR;
         ST_UP_IR: state_next = tms ? ST_SEL_DR : ST_RTI;
         default: state_next = ST_TLR;
      endcase
   end

   // ID bus register is the low end of the boundary chain
   always @* begin
      case (dr_sel)
         `SLK_DR_BSR: dr_lsb = bsr_reg[0];
         `SLK_DR_CTRL: dr_lsb = ctrl_shift_reg[0];
         `SLK_DR_CNT: dr_lsb = cnt_shift_reg[0];
         `SLK_DR_IDB: dr_lsb = bsr_reg[0];
         `SLK_DR_SEL: dr_lsb = sel_shift_reg[0];
         default: dr_lsb = bypass_reg;
      endcase
   end

   // TAP state and instruction path, all on test-clock rising edges
   always @(posedge CORE_CLK_I) begin
      if (RST_I || !trst_n) begin
         tck_prev_reg <= 1'b0;
         state_reg <= ST_TLR;
         ir_shift_reg <= `SLK_IR_RESET;
         ir_latch_reg <= `SLK_IR_RESET;
         perr_n_latch_reg <= 1'b1;
         test_mode_reg <= 1'b0;
      end else begin
         tck_prev_reg <= tck;
         if (tck_rise) begin
            state_reg <= state_next;
            case (state_reg)
               ST_TLR: begin
                  ir_latch_reg <= `SLK_IR_RESET;
                  perr_n_latch_reg <= 1'b1;
                  test_mode_reg <= 1'b0;
               end
               ST_CAP_IR: begin
                  ir_shift_reg <= `SLK_ST_FIXED;
                  ir_shift_reg[`SLK_ST_PERR] <= perr_n_latch_reg;
                  ir_shift_reg[`SLK_ST_COND] <= cond_active;
               end
               ST_SH_IR: ir_shift_reg <= {tdi, ir_shift_reg[`SLK_IR_W-1:1]};
               ST_UP_IR: begin
                  ir_latch_reg <= ir_shift_reg;
                  perr_n_latch_reg <= perr_n;
                  test_mode_reg <= is_test_op(ir_shift_reg);
               end
               default: ir_latch_reg <= ir_latch_reg;
            endcase
         end
      end
   end

   // Data registers and counter
   always @(posedge CORE_CLK_I) begin
      if (RST_I || !trst_n || (tck_rise && state_reg == ST_TLR)) begin
         bypass_reg <= 1'b0;
         bsr_reg <= {`SLK_BSR_W{1'b0}};
         bsr_latch_reg <= {`SLK_BSR_W{1'b0}};
         ctrl_shift_reg <= `SLK_CTRL_RESET;
         ctrl_reg <= `SLK_CTRL_RESET;
         cnt_shift_reg <= `SLK_CNT_ZERO;
         count_reg <= `SLK_CNT_ZERO;
         preload_reg <= `SLK_CNT_ZERO;
         sel_shift_reg <= {`SLK_SEL_W{1'b0}};
         sel_reg <= {`SLK_SEL_W{1'b0}};
         cond_prev_reg <= 1'b0;
      end else begin
         cond_prev_reg <= cond_active;
         if (tck_rise && state_reg == ST_CAP_DR) begin
            case (dr_sel)
               `SLK_DR_BSR: bsr_reg <= {CONDITION_OUT_O, cond_pin, idbus};
               `SLK_DR_CNT: cnt_shift_reg <= (ir_latch_reg == `SLK_OP_CNT_SCAN) ? count_reg : preload_reg;
               `SLK_DR_IDB: begin
                  if (ir_latch_reg == `SLK_OP_IDB_SCAN) begin
                     bsr_reg[`SLK_IDB_W-1:0] <= idbus;
                  end
               end
               `SLK_DR_BYPASS: bypass_reg <= 1'b0;
               default: bypass_reg <= bypass_reg;
            endcase
         end else if (tck_rise && state_reg == ST_SH_DR) begin
            case (dr_sel)
               `SLK_DR_BSR: bsr_reg <= {dr_in, bsr_reg[`SLK_BSR_W-1:1]};
               `SLK_DR_CTRL: ctrl_shift_reg <= {dr_in, ctrl_shift_reg[`SLK_CTRL_W-1:1]};
               `SLK_DR_CNT: cnt_shift_reg <= {dr_in, cnt_shift_reg[`SLK_CNT_W-1:1]};
               `SLK_DR_IDB: bsr_reg[`SLK_IDB_W-1:0] <= {dr_in, bsr_reg[`SLK_IDB_W-1:1]};
               `SLK_DR_SEL: sel_shift_reg <= {dr_in, sel_shift_reg[`SLK_SEL_W-1:1]};
               default: bypass_reg <= dr_in;
            endcase
         end else if (tck_rise && state_reg == ST_UP_DR) begin
            case (dr_sel)
               `SLK_DR_BSR: bsr_latch_reg <= bsr_reg;
               `SLK_DR_CTRL: ctrl_reg <= ctrl_shift_reg;
               `SLK_DR_CNT: begin
                  count_reg <= cnt_shift_reg;
                  preload_reg <= cnt_shift_reg;
               end
               `SLK_DR_SEL: sel_reg <= sel_shift_reg;
               default: bsr_latch_reg <= bsr_latch_reg;
            endcase
         // Paced by the core clock, since the test clock may stand still in idle
         end else if (count_op && state_reg == ST_RTI && cond_active && !cond_prev_reg) begin
            // No clear on entry, so a count instruction carries on from the held value
            if (!ctrl_reg[`SLK_CT_DOWN]) begin
               count_reg <= count_reg + `SLK_CNT_ONE;
            end else if (!(ctrl_reg[`SLK_CT_LATCH0] && count_reg == `SLK_CNT_ZERO)) begin
               count_reg <= count_reg - `SLK_CNT_ONE;
            end
         end
      end
   end

   // Condition output and serial output, changed on falling test-clock edges
   reg src_act;
   reg cond_lvl;
   always @* begin
      case (ctrl_reg[`SLK_CT_SRC_HI:`SLK_CT_SRC_LO])
         `SLK_SRC_PERR: src_act = (state_reg == ST_PA_IR) && !perr_n && !ctrl_reg[`SLK_CT_MASK];
         `SLK_SRC_TERM: src_act = ctrl_reg[`SLK_CT_DOWN] ? (count_reg == `SLK_CNT_ZERO) : (count_reg == `SLK_CNT_FULL);
         `SLK_SRC_COND: src_act = cond_active;
         default: src_act = 1'b0;
      endcase
      cond_lvl = src_act ~^ ctrl_reg[`SLK_CT_OUT_POL];
   end

   always @(posedge CORE_CLK_I) begin
      if (RST_I || !trst_n) begin
         tdo_reg <= 1'b1;
         tdo_oe_reg <= 1'b0;
         cond_out_reg <= 1'b1;
         cond_oe_reg <= 1'b0;
      end else if (tck_fall) begin
         // Enable follows the state entered at the last rise
         tdo_oe_reg <= (state_reg == ST_SH_IR) || (state_reg == ST_SH_DR);
         tdo_reg <= (state_reg == ST_SH_IR) ? ir_shift_reg[0] : dr_lsb;
         if (test_mode) begin
            cond_out_reg <= bsr_latch_reg[`SLK_BSR_W-1];
            cond_oe_reg <= 1'b1;
         end else if (!ctrl_reg[`SLK_CT_OUT_EN]) begin
            // Disabled open drain floats high, disabled 3-state floats
            cond_out_reg <= 1'b1;
            cond_oe_reg <= 1'b0;
         end else if (ctrl_reg[`SLK_CT_TRISTATE]) begin
            cond_out_reg <= cond_lvl;
            cond_oe_reg <= 1'b1;
         end else begin
            cond_out_reg <= 1'b0;
            cond_oe_reg <= !cond_lvl;
         end
      end
   end

   assign TDO_O = tdo_reg;
   assign TDO_OE_O = tdo_oe_reg;
   assign CONDITION_OUT_O = cond_out_reg;
   assign CONDITION_OUT_OE_O = cond_oe_reg;
   assign PATH_SELECT_O = sel_reg;
   assign TEST_MODE_O = test_mode;
   assign PINS_DISABLE_O = ctrl_reg[`SLK_CT_PIN_DIS];
   assign COUNT_O = count_reg;

endmodule // slk_ir_decode

//--- design/slk_consts.vh
`ifndef SLK_CONSTS_VH
`define SLK_CONSTS_VH

// Widths
`define SLK_IR_W 8
`define SLK_CTRL_W 10
`define SLK_CNT_W 8
`define SLK_SEL_W 4
`define SLK_IDB_W 4
`define SLK_BSR_W 6
`define SLK_SYNC_W 10

// Opcodes, all eight bits compared
`define SLK_OP_EXTEST 8'h00
`define SLK_OP_INTEST 8'h03
`define SLK_OP_SAMPLE 8'h82
`define SLK_OP_COUNT_A 8'h88
`define SLK_OP_COUNT_B 8'h09
`define SLK_OP_CTRL_A 8'h8e
`define SLK_OP_CTRL_B 8'h0f
`define SLK_OP_CNT_SCAN 8'hfa
`define SLK_OP_CNT_READ 8'h7b
`define SLK_OP_IDB_SCAN 8'hfc
`define SLK_OP_IDB_READ 8'h7d
`define SLK_OP_SEL_SCAN 8'h7e
`define SLK_IR_RESET 8'hff

// Data register selection codes
`define SLK_DR_BYPASS 3'h0
`define SLK_DR_BSR 3'h1
`define SLK_DR_CTRL 3'h2
`define SLK_DR_CNT 3'h3
`define SLK_DR_IDB 3'h4
`define SLK_DR_SEL 3'h5

// Status word bit positions and fixed bits
`define SLK_ST_PERR 7
`define SLK_ST_COND 3
`define SLK_ST_FIXED 8'h01

// Control register fields
`define SLK_CT_DOWN 9
`define SLK_CT_LATCH0 8
`define SLK_CT_OUT_POL 7
`define SLK_CT_SRC_HI 6
`define SLK_CT_SRC_LO 5
`define SLK_CT_MASK 4
`define SLK_CT_TRISTATE 3
`define SLK_CT_OUT_EN 2
`define SLK_CT_IN_POL 1
`define SLK_CT_PIN_DIS 0
`define SLK_CTRL_RESET 10'h000

// Condition output sources
`define SLK_SRC_NONE 2'h0
`define SLK_SRC_PERR 2'h1
`define SLK_SRC_TERM 2'h2
`define SLK_SRC_COND 2'h3

// Counter values
`define SLK_CNT_ZERO 8'h00
`define SLK_CNT_FULL 8'hff
`define SLK_CNT_ONE 8'h01

// Synchroniser bit positions
`define SLK_SY_TCK 0
`define SLK_SY_TMS 1
`define SLK_SY_TDI 2
`define SLK_SY_TRST 3
`define SLK_SY_RET 4
`define SLK_SY_COND 5
`define SLK_SY_IDB 6

`endif

//--- design/slk_sync.v
`timescale 1ns/1ns
`include "slk_consts.vh"

module slk_sync (
   input wire clk_i,          // core clock
   input wire rst_i,          // synchronous reset
   input wire [`SLK_SYNC_W-1:0] async_i, // pins from outside
   output wire [`SLK_SYNC_W-1:0] stable_o // filtered levels
);

   reg [`SLK_SYNC_W-1:0] s1_reg;
   reg [`SLK_SYNC_W-1:0] s2_reg;
   reg [`SLK_SYNC_W-1:0] s3_reg;
   reg [`SLK_SYNC_W-1:0] stable_reg;

   genvar g;
   generate
      for (g = 0; g < `SLK_SYNC_W; g = g + 1) begin : g_bit
         always @(posedge clk_i) begin
            if (rst_i) begin
               s1_reg[g] <= 1'b0;
               s2_reg[g] <= 1'b0;
               s3_reg[g] <= 1'b0;
               stable_reg[g] <= 1'b0;
            end else begin
               s1_reg[g] <= async_i[g];
               s2_reg[g] <= s1_reg[g];
               s3_reg[g] <= s2_reg[g];
               // Change accepted only once two late stages agree
               if (s2_reg[g] == s3_reg[g]) begin
                  stable_reg[g] <= s3_reg[g];
               end
            end
         end
      end
   endgenerate

   assign stable_o = stable_reg;

endmodule // slk_sync

//--- bench/slk_pbc_model.sv
`timescale 1ns/1ns
module slk_pbc_model (
   input wire clk_i, // core clock, paces the test clock
   input wire tdo_i, // serial data from the device
   output reg tck_o, // test clock, still between frames
   output reg tms_o, // mode select
   output reg tdi_o // serial data to the device
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   end
   // Drive while low, read two clocks after the rise; 8 core clocks a period
   task step(input reg tms, input reg tdi, output reg tdo);
      begin
         tms_o <= tms;
         tdi_o <= tdi;
         repeat (4) @(posedge clk_i);
         tck_o <= 1'b1;
         repeat (2) @(posedge clk_i);
         tdo = tdo_i;
         repeat (2) @(posedge clk_i);
         tck_o <= 1'b0;
      end
   endtask
   // From Run-Test/Idle through one scan and back; bit 0 goes first
   task scan(input reg ir, input reg [15:0] v, input integer n, output reg [15:0] cap);
      integer i;
      reg b;
      begin
         cap = 16'h0000;
         step(1'b1, 1'b1, b);
         if (ir) step(1'b1, 1'b1, b);
         step(1'b0, 1'b1, b);
         step(1'b0, 1'b1, b);
         for (i = 0; i < n; i = i + 1) begin
            step(i == n - 1, v[i], b);
            cap[i] = b;
         end
         step(1'b1, 1'b1, b);
         step(1'b0, 1'b1, b);
         tdi_o <= 1'b1; // Pull-up level once released
      end
   endtask
endmodule // slk_pbc_model

//--- bench/slk_ir_decode_monitor.sv
`timescale 1ns/1ns
`include "slk_consts.vh"
module slk_ir_decode_monitor (
   input wire CORE_CLK_I, // core clock
   input wire RST_I, // synchronous reset
   input wire TCK_I, // test clock
   input wire TMS_I, // mode select
   input wire TDI_I, // serial in
   input wire TRST_N_I, // test reset, active low
   input wire SECONDARY_DATA_RETURN_I, // serial return
   input wire CONDITION_IN_I, // condition input
   input wire [`SLK_IDB_W-1:0] IDBUS_I, // identification bus
   input wire TDO_O, // serial out
   input wire TDO_OE_O, // serial out enable
   input wire CONDITION_OUT_O, // condition output
   input wire CONDITION_OUT_OE_O, // condition output enable
   input wire [`SLK_SEL_W-1:0] PATH_SELECT_O, // select latch
   input wire TEST_MODE_O, // test mode
   input wire PINS_DISABLE_O, // pins disabled
   input wire [`SLK_CNT_W-1:0] COUNT_O // counter
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   sequence trst_hold;
      !TRST_N_I [*8];
   endsequence
   // Sync delay is 4 clocks, so 8 quiet clocks cover any pending update
   sequence tck_quiet;
      (TRST_N_I && $stable(TCK_I)) [*8];
   endsequence
   reset_vals_a: assert property ($fell(RST_I) |-> TDO_O && !TDO_OE_O && CONDITION_OUT_O && !CONDITION_OUT_OE_O
      && PATH_SELECT_O == 4'h0 && !TEST_MODE_O && !PINS_DISABLE_O && COUNT_O == 8'h00) else $error("reset values");
   trst_clear_a: assert property (trst_hold |-> PATH_SELECT_O == 4'h0 && !TEST_MODE_O && COUNT_O == 8'h00)
      else $error("test reset did not clear");
   tdo_timing_a: assert property ($changed(TDO_O) |-> !$past(TCK_I, 2)) else $error("serial out moved at rise");
   oe_timing_a: assert property ($changed(TDO_OE_O) |-> !$past(TCK_I, 2)) else $error("enable moved at rise");
   mode_hold_a: assert property (TDO_OE_O |-> $stable(TEST_MODE_O)) else $error("mode changed in shift");
   sel_hold_a: assert property (TDO_OE_O |-> $stable(PATH_SELECT_O) && $stable(PINS_DISABLE_O))
      else $error("latch changed in shift");
   count_hold_a: assert property (TDO_OE_O |-> $stable(COUNT_O)) else $error("counted outside idle");
   idle_quiet_a: assert property (tck_quiet |-> $stable(TEST_MODE_O) && $stable(PATH_SELECT_O))
      else $error("latch changed without test clock");
endmodule // slk_ir_decode_monitor
bind slk_ir_decode slk_ir_decode_monitor u_mon (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .TCK_I(TCK_I),
   .TMS_I(TMS_I), .TDI_I(TDI_I), .TRST_N_I(TRST_N_I), .SECONDARY_DATA_RETURN_I(SECONDARY_DATA_RETURN_I),
   .CONDITION_IN_I(CONDITION_IN_I), .IDBUS_I(IDBUS_I), .TDO_O(TDO_O), .TDO_OE_O(TDO_OE_O),
   .CONDITION_OUT_O(CONDITION_OUT_O), .CONDITION_OUT_OE_O(CONDITION_OUT_OE_O), .PATH_SELECT_O(PATH_SELECT_O),
   .TEST_MODE_O(TEST_MODE_O), .PINS_DISABLE_O(PINS_DISABLE_O), .COUNT_O(COUNT_O));

//--- bench/tb_slk_ir_decode.sv
`timescale 1ns/1ns
`include "slk_consts.vh"
`define CHK(n, e, s) begin comparisons = comparisons + 1; if ((s) !== (e)) begin error_cnt = error_cnt + 1; $display("[FAIL] %s exp %h seen %h", n, e, s); end end
module tb_slk_ir_decode;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg trst_n = 1'b1;
   reg ret = 1'b0;
   reg cond = 1'b1;
   reg [3:0] idbus = 4'h0;
   wire tck, tms, tdi, tdo, tdo_oe, co, co_oe, tm, pd;
   wire [3:0] sel;
   wire [7:0] cnt;
   integer error_cnt = 0;
   integer comparisons = 0;
   integer cyc = 0;
   integer i;
   integer seed = 32'h3f87dc89;
   reg [15:0] cap;
   reg [7:0] op, prev, v;
   reg [7:0] hand [0:11] = '{8'h00, 8'h03, 8'h82, 8'h81, 8'h84, 8'h05, 8'h06, 8'h87, 8'h0a, 8'h8b, 8'h0c, 8'h8d};
   always #20 clk = ~clk;
   // A released serial output reads inverted, so a missing enable shows up
   slk_pbc_model u_pbc (.clk_i(clk), .tdo_i(tdo_oe ? tdo : ~tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
   slk_ir_decode u_dut (.CORE_CLK_I(clk), .RST_I(rst), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi), .TRST_N_I(trst_n),
      .SECONDARY_DATA_RETURN_I(ret), .CONDITION_IN_I(cond), .IDBUS_I(idbus), .TDO_O(tdo), .TDO_OE_O(tdo_oe),
      .CONDITION_OUT_O(co), .CONDITION_OUT_OE_O(co_oe), .PATH_SELECT_O(sel), .TEST_MODE_O(tm),
      .PINS_DISABLE_O(pd), .COUNT_O(cnt));
   function is_byp(input [7:0] o);
      case (o)
         8'h00, 8'h03, 8'h82, 8'h8e, 8'h0f, 8'hfa, 8'h7b, 8'hfc, 8'h7d, 8'h7e: is_byp = 1'b0;
         default: is_byp = 1'b1;
      endcase
   endfunction
   task end_of_test;
      begin
         $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
         if (error_cnt == 0 && comparisons > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task ir(input [7:0] o);
      begin
         u_pbc.scan(1'b1, {8'h00, o}, 8, cap);
         repeat (2) @(posedge clk);
      end
   endtask
   task dr(input [15:0] d, input integer n);
      begin
         u_pbc.scan(1'b0, d, n, cap);
         repeat (2) @(posedge clk);
      end
   endtask
   // Active low by default, so the falling edge is the counted one
   task toggle(input integer n);
      integer k;
      begin
         for (k = 0; k < n; k = k + 1) begin
            cond <= 1'b0;
            repeat (8) @(posedge clk);
            cond <= 1'b1;
            repeat (8) @(posedge clk);
         end
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt = error_cnt + 1;
         end_of_test;
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      `CHK("oe", 1'b0, tdo_oe)
      `CHK("sel", 4'h0, sel)
      `CHK("count", 8'h00, cnt)
      u_pbc.step(1'b0, 1'b1, cap[0]);
      prev = 8'hff;
      for (i = 0; i < 24; i = i + 1) begin
         op = (i < 12) ? hand[i] : $random(seed);
         cond <= $random(seed);
         idbus <= $random(seed);
         repeat (8) @(posedge clk);
         ir(op);
         `CHK("status", {~^prev, 3'b000, ~cond, 3'b001}, cap[7:0])
         `CHK("test", (op == 8'h00 || op == 8'h03), tm)
         v = $random(seed);
         if (is_byp(op)) begin
            dr({8'h00, v}, 8);
            `CHK("bypass", {v[6:0], 1'b0}, cap[7:0])
         end else if (!(op & 8'h7c)) begin
            dr(16'h0000, 6);
            `CHK("sample", idbus, cap[3:0])
         end
         prev = op;
      end
      cond <= 1'b1;
      ir(8'h7e);
      dr(16'h000a, 4);
      `CHK("sel", 4'ha, sel)
      ret <= 1'b1;
      ir(8'hff);
      dr(16'h0000, 8);
      `CHK("return", 8'hfe, cap[7:0])
      ir(8'h7e);
      dr(16'h0000, 4);
      `CHK("sel", 4'h0, sel)
      ir(8'hfa);
      dr(16'h0010, 8);
      `CHK("count", 8'h10, cnt)
      ir(8'h88);
      toggle(5);
      `CHK("count", 8'h15, cnt)
      ir(8'hfa);
      dr(16'h0015, 8);
      `CHK("capture", 8'h15, cap[7:0])
      ir(8'h8e);
      dr(16'h0001, 10);
      `CHK("pins", 1'b1, pd)
      dr(16'h0200, 10);
      `CHK("ctrl", 10'h001, cap[9:0])
      `CHK("pins", 1'b0, pd)
      ir(8'h09);
      toggle(3);
      `CHK("count", 8'h12, cnt)
      ir(8'h7b);
      dr(16'h0040, 8);
      `CHK("preload", 8'h15, cap[7:0])
      `CHK("count", 8'h40, cnt)
      ir(8'h8e);
      dr(16'h00ac, 10);
      repeat (4) @(posedge clk);
      `CHK("cond out", 2'b01, {co, co_oe})
      u_pbc.step(1'b1, 1'b1, cap[0]);
      u_pbc.step(1'b1, 1'b1, cap[0]);
      u_pbc.step(1'b0, 1'b1, cap[0]);
      u_pbc.step(1'b0, 1'b1, cap[0]);
      v = 8'h01;
      for (i = 0; i < 8; i = i + 1)
         u_pbc.step(i == 7, v[i], cap[i]);
      u_pbc.step(1'b0, 1'b1, cap[0]);
      repeat (6) @(posedge clk);
      `CHK("parity out", 2'b11, {co, co_oe})
      u_pbc.step(1'b1, 1'b1, cap[0]);
      u_pbc.step(1'b1, 1'b1, cap[0]);
      u_pbc.step(1'b0, 1'b1, cap[0]);
      repeat (2) @(posedge clk);
      ir(8'h03);
      `CHK("status", 8'h01, cap[7:0])
      `CHK("test", 1'b1, tm)
      dr(16'h0020, 6);
      repeat (4) @(posedge clk);
      `CHK("drive", 2'b11, {co, co_oe})
      trst_n <= 1'b0;
      repeat (12) @(posedge clk);
      trst_n <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK("test", 1'b0, tm)
      `CHK("count", 8'h00, cnt)
      end_of_test;
   end
endmodule // tb_slk_ir_decode
